// >>> rtl/lmc_pkg.sv
package lmc_pkg;

	localparam int CLK_PERIOD_NS = 8;

	// pin timings in ns; the defaults are plain values, adjust per part grade
	localparam int T_MODE_NS      = 10_000;
	localparam int T_RELEASE_NS   = 10_000;
	localparam int T_FL_ENLOW_NS  = 100_000;
	localparam int T_FL_TXA_NS    = 10_000;
	localparam int T_FL_TXB_NS    = 10_000;
	localparam int T_FL_TXC_NS    = 10_000;
	localparam int T_PROBE_NS     = 5_000;

	// least times, rounded up to whole cycles
	localparam int MODE_CYC     = (T_MODE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RELEASE_CYC  = (T_RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FL_ENLOW_CYC = (T_FL_ENLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FL_TXA_CYC   = (T_FL_TXA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FL_TXB_CYC   = (T_FL_TXB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FL_TXC_CYC   = (T_FL_TXC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PROBE_CYC    = (T_PROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam int TIMER_W = 24;

	// register byte offsets
	localparam logic [3:0] ADR_CMD    = 4'h0;
	localparam logic [3:0] ADR_TXBIT  = 4'h4;
	localparam logic [3:0] ADR_STATUS = 4'h8;
	localparam logic [3:0] ADR_WAKE   = 4'hC;

	// status field positions
	localparam int STS_BUSY     = 0;
	localparam int STS_RELEASED = 1;
	localparam int STS_FLASH    = 2;
	localparam int STS_ENABLE   = 3;
	localparam int STS_RX       = 4;
	localparam int STS_REFUSED  = 5;

	// wake register field positions
	localparam int WK_VALID = 0;
	localparam int WK_EVENT = 1;
	localparam int WK_LOCAL = 2;

	localparam logic [2:0] CMD_NONE   = 3'h0;
	localparam logic [2:0] CMD_NORMAL = 3'h1;
	localparam logic [2:0] CMD_SLEEP  = 3'h2;
	localparam logic [2:0] CMD_FLASH  = 3'h3;
	localparam logic [2:0] CMD_PROBE  = 3'h4;

	localparam logic TXBIT_RESET = 1'b1;

	typedef enum logic [3:0] {
		S_SLEEP,
		S_MODE,
		S_RELEASE,
		S_ACTIVE,
		S_FL_ENLOW,
		S_FL_TXLOW,
		S_FL_TXHIGH,
		S_FL_ENHIGH,
		S_PROBE
	} lmc_state_type;

	typedef struct packed {
		logic en;
		logic txd_o;
		logic txd_oe;
	} lmc_pins_type;

	localparam lmc_pins_type PINS_RESET = '{en: 1'b0, txd_o: 1'b1, txd_oe: 1'b0};

endpackage : lmc_pkg

// >>> rtl/lmc_timer.sv
module lmc_timer #(
	parameter int W = 24
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         load,
	input  wire logic [W-1:0] load_val,
	output logic              expired
);

	logic [W-1:0] count_q;
	logic [W-1:0] count_d;
	logic         expired_q;
	logic         expired_d;

	always_comb begin
		count_d = count_q;
		if (load) begin
			count_d = load_val;
		end else if (count_q != '0) begin
			count_d = count_q - W'(1);
		end
		expired_d = (count_d == '0);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			count_q   <= '0;
			expired_q <= 1'b1;
		end else begin
			count_q   <= count_d;
			expired_q <= expired_d;
		end
	end

	assign expired = expired_q;

endmodule : lmc_timer

// >>> rtl/lmc_ctrl.sv
// Behaviour
// - transmit held high for release before sending
// - enable low, then transmit fall and rise
// - same sequence leaves fast; re-release transmit
// - host drives transmit high to read source
//
// The Wishbone slave port and the register addresses were left to the implementer.
module lmc_ctrl #(
	parameter int MODE_CYC     = lmc_pkg::MODE_CYC,
	parameter int RELEASE_CYC  = lmc_pkg::RELEASE_CYC,
	parameter int FL_ENLOW_CYC = lmc_pkg::FL_ENLOW_CYC,
	parameter int FL_TXA_CYC   = lmc_pkg::FL_TXA_CYC,
	parameter int FL_TXB_CYC   = lmc_pkg::FL_TXB_CYC,
	parameter int FL_TXC_CYC   = lmc_pkg::FL_TXC_CYC,
	parameter int PROBE_CYC    = lmc_pkg::PROBE_CYC
) (
	input  wire logic        CLK,
	input  wire logic        RST,
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	input  wire logic        WB_WE_I,
	input  wire logic [3:0]  WB_ADR_I,
	input  wire logic [3:0]  WB_SEL_I,
	input  wire logic [31:0] WB_DAT_I,
	output logic      [31:0] WB_DAT_O,
	output logic             WB_ACK_O,
	output logic             EN,
	output logic             TXD_O,
	output logic             TXD_OE,
	input  wire logic        TXD_I,
	input  wire logic        RXD_I
);

	localparam int TW = lmc_pkg::TIMER_W;

	lmc_pkg::lmc_state_type state_q;
	lmc_pkg::lmc_state_type state_d;
	lmc_pkg::lmc_pins_type  pins_q;
	lmc_pkg::lmc_pins_type  pins_d;
	logic                   flash_q;
	logic                   flash_d;
	logic                   txbit_q;
	logic                   txbit_d;
	logic                   refused_q;
	logic                   refused_d;
	logic [2:0]             wake_q;
	logic [2:0]             wake_d;
	logic                   ack_q;
	logic                   ack_d;
	logic [31:0]            dat_q;
	logic [31:0]            dat_d;
	logic                   tmr_load;
	logic [TW-1:0]          tmr_val;
	logic                   tmr_done;
	logic                   wr_take;
	logic [2:0]             cmd;
	logic [31:0]            status;

	// bus slave: ack one cycle after the request, write lands on the ack edge
	always_comb begin
		ack_d   = WB_CYC_I && WB_STB_I && !ack_q;
		wr_take = WB_CYC_I && WB_STB_I && WB_WE_I && ack_q && WB_SEL_I[0];
		cmd     = lmc_pkg::CMD_NONE;
		if (wr_take && WB_ADR_I == lmc_pkg::ADR_CMD) begin
			cmd = WB_DAT_I[2:0];
		end
		txbit_d = txbit_q;
		if (wr_take && WB_ADR_I == lmc_pkg::ADR_TXBIT) begin
			txbit_d = WB_DAT_I[0];
		end
		status = '0;
		status[lmc_pkg::STS_BUSY]     = (state_q != lmc_pkg::S_SLEEP)
			&& (state_q != lmc_pkg::S_ACTIVE);
		status[lmc_pkg::STS_RELEASED] = (state_q == lmc_pkg::S_ACTIVE);
		status[lmc_pkg::STS_FLASH]    = flash_q;
		status[lmc_pkg::STS_ENABLE]   = pins_q.en;
		status[lmc_pkg::STS_RX]       = RXD_I;
		status[lmc_pkg::STS_REFUSED]  = refused_q;
		dat_d = '0;
		if (ack_d && !WB_WE_I) begin
			case (WB_ADR_I)
				lmc_pkg::ADR_TXBIT:  dat_d = {31'h0000_0000, txbit_q};
				lmc_pkg::ADR_STATUS: dat_d = status;
				lmc_pkg::ADR_WAKE:   dat_d = {29'h0000_0000, wake_q};
				default:             dat_d = '0;
			endcase
		end
	end

	always_comb begin
		state_d   = state_q;
		flash_d   = flash_q;
		wake_d    = wake_q;
		refused_d = refused_q;
		if (cmd != lmc_pkg::CMD_NONE) begin
			refused_d = 1'b0;
		end
		case (state_q)
			lmc_pkg::S_SLEEP: begin
				if (cmd == lmc_pkg::CMD_NORMAL) begin
					state_d = lmc_pkg::S_MODE;
					wake_d  = '0;
				end else if (cmd == lmc_pkg::CMD_PROBE) begin
					state_d = lmc_pkg::S_PROBE;
				end else if (cmd != lmc_pkg::CMD_NONE) begin
					refused_d = 1'b1;
				end
			end
			lmc_pkg::S_MODE: begin
				if (cmd == lmc_pkg::CMD_SLEEP) begin
					state_d = lmc_pkg::S_SLEEP;
				end else if (tmr_done) begin
					state_d = lmc_pkg::S_RELEASE;
				end
			end
			lmc_pkg::S_RELEASE: begin
				if (cmd == lmc_pkg::CMD_SLEEP) begin
					state_d = lmc_pkg::S_SLEEP;
					flash_d = 1'b0;
				end else if (tmr_done) begin
					state_d = lmc_pkg::S_ACTIVE;
				end
			end
			lmc_pkg::S_ACTIVE: begin
				if (cmd == lmc_pkg::CMD_SLEEP) begin
					state_d = lmc_pkg::S_SLEEP;
					flash_d = 1'b0;
				end else if (cmd == lmc_pkg::CMD_FLASH) begin
					state_d = lmc_pkg::S_FL_ENLOW;
				end else if (cmd != lmc_pkg::CMD_NONE) begin
					refused_d = 1'b1;
				end
			end
			lmc_pkg::S_FL_ENLOW: begin
				if (tmr_done) begin
					state_d = lmc_pkg::S_FL_TXLOW;
				end
			end
			lmc_pkg::S_FL_TXLOW: begin
				if (tmr_done) begin
					state_d = lmc_pkg::S_FL_TXHIGH;
				end
			end
			lmc_pkg::S_FL_TXHIGH: begin
				if (tmr_done) begin
					state_d = lmc_pkg::S_FL_ENHIGH;
				end
			end
			lmc_pkg::S_FL_ENHIGH: begin
				if (tmr_done) begin
					state_d = lmc_pkg::S_RELEASE;
					flash_d = !flash_q;
				end
			end
			lmc_pkg::S_PROBE: begin
				if (tmr_done) begin
					state_d = lmc_pkg::S_SLEEP;
					wake_d[lmc_pkg::WK_VALID] = 1'b1;
					wake_d[lmc_pkg::WK_EVENT] = !RXD_I;
					wake_d[lmc_pkg::WK_LOCAL] = !RXD_I && !TXD_I;
				end
			end
			default: state_d = lmc_pkg::S_SLEEP;
		endcase
	end

	// pins follow the next state so that they leave a flip-flop in step with it
	always_comb begin
		pins_d = lmc_pkg::PINS_RESET;
		case (state_d)
			lmc_pkg::S_SLEEP: pins_d = lmc_pkg::PINS_RESET;
			lmc_pkg::S_MODE, lmc_pkg::S_RELEASE, lmc_pkg::S_FL_ENHIGH: begin
				pins_d = '{en: 1'b1, txd_o: 1'b1, txd_oe: 1'b1};
			end
			lmc_pkg::S_ACTIVE: pins_d = '{en: 1'b1, txd_o: txbit_d, txd_oe: 1'b1};
			lmc_pkg::S_FL_ENLOW, lmc_pkg::S_FL_TXHIGH, lmc_pkg::S_PROBE: begin
				pins_d = '{en: 1'b0, txd_o: 1'b1, txd_oe: 1'b1};
			end
			lmc_pkg::S_FL_TXLOW: pins_d = '{en: 1'b0, txd_o: 1'b0, txd_oe: 1'b1};
			default: pins_d = lmc_pkg::PINS_RESET;
		endcase
	end

	always_comb begin
		tmr_load = (state_d != state_q);
		case (state_d)
			lmc_pkg::S_MODE:      tmr_val = TW'(MODE_CYC);
			lmc_pkg::S_RELEASE:   tmr_val = TW'(RELEASE_CYC);
			lmc_pkg::S_FL_ENLOW:  tmr_val = TW'(FL_ENLOW_CYC);
			lmc_pkg::S_FL_TXLOW:  tmr_val = TW'(FL_TXA_CYC);
			lmc_pkg::S_FL_TXHIGH: tmr_val = TW'(FL_TXB_CYC);
			lmc_pkg::S_FL_ENHIGH: tmr_val = TW'(FL_TXC_CYC);
			lmc_pkg::S_PROBE:     tmr_val = TW'(PROBE_CYC);
			default:              tmr_val = TW'(1);
		endcase
	end

	lmc_timer #(
		.W(TW)
	) u_timer (
		.clk      (CLK),
		.rst      (RST),
		.load     (tmr_load),
		.load_val (tmr_val),
		.expired  (tmr_done)
	);

	always_ff @(posedge CLK) begin
		if (RST) begin
			state_q   <= lmc_pkg::S_SLEEP;
			pins_q    <= lmc_pkg::PINS_RESET;
			flash_q   <= 1'b0;
			txbit_q   <= lmc_pkg::TXBIT_RESET;
			refused_q <= 1'b0;
			wake_q    <= '0;
			ack_q     <= 1'b0;
			dat_q     <= '0;
		end else begin
			state_q   <= state_d;
			pins_q    <= pins_d;
			flash_q   <= flash_d;
			txbit_q   <= txbit_d;
			refused_q <= refused_d;
			wake_q    <= wake_d;
			ack_q     <= ack_d;
			dat_q     <= dat_d;
		end
	end

	assign WB_ACK_O = ack_q;
	assign WB_DAT_O = dat_q;
	assign EN       = pins_q.en;
	assign TXD_O    = pins_q.txd_o;
	assign TXD_OE   = pins_q.txd_oe;

	// helper run-length counters seen only by the checks below
	logic [TW-1:0] txhigh_run_q;
	logic [TW-1:0] enlow_run_q;

	always_ff @(posedge CLK) begin
		if (RST) begin
			txhigh_run_q <= '0;
			enlow_run_q  <= '0;
		end else begin
			txhigh_run_q <= (pins_q.txd_oe && pins_q.txd_o) ? txhigh_run_q + TW'(1) : '0;
			enlow_run_q  <= (!pins_q.en) ? enlow_run_q + TW'(1) : '0;
		end
	end

	a_release_tx_high: assert property (@(posedge CLK) disable iff (RST)
		$rose(state_q == lmc_pkg::S_ACTIVE) |-> txhigh_run_q >= TW'(RELEASE_CYC))
		else $error("transmission released before transmit high time");

	a_flash_en_low: assert property (@(posedge CLK) disable iff (RST)
		$fell(pins_q.txd_o) && pins_q.txd_oe && !pins_q.en
			|-> enlow_run_q > TW'(FL_ENLOW_CYC))
		else $error("flash transmit fall too soon after enable low");

	a_flash_edge_pair: assert property (@(posedge CLK) disable iff (RST)
		$fell(pins_q.txd_o) && !pins_q.en |-> (!pins_q.txd_o && !pins_q.en)[*2])
		else $error("flash transmit low phase too short");

	a_flash_toggle: assert property (@(posedge CLK) disable iff (RST)
		$changed(flash_q) && flash_q |-> $past(state_q) == lmc_pkg::S_FL_ENHIGH
			&& state_q == lmc_pkg::S_RELEASE)
		else $error("fast sub-mode flag changed outside the edge sequence");

	a_probe_drive: assert property (@(posedge CLK) disable iff (RST)
		$rose(wake_q[lmc_pkg::WK_VALID]) |-> $past(pins_q.txd_oe && pins_q.txd_o && !pins_q.en))
		else $error("wake source sampled without driving transmit high");

	a_mode_delay: assert property (@(posedge CLK) disable iff (RST)
		$rose(pins_q.en) && !flash_q && state_q == lmc_pkg::S_MODE
			|-> (state_q != lmc_pkg::S_ACTIVE)[*8])
		else $error("normal entry finished without mode delay");

endmodule : lmc_ctrl

// >>> tb/lmc_xcvr_model.sv
module lmc_xcvr_model #(
	parameter int MODE = 8,
	parameter int REL  = 8,
	parameter int FL1  = 8,
	parameter int BW   = 20,
	parameter int LW   = 20
) (
	input  wire logic       clk,
	input  wire logic       en,
	input  wire logic       txd,
	input  wire logic       bus_dom,
	input  wire logic       wk_n,
	output logic            rxd,
	output logic            pd_weak,
	output logic            pd_strong,
	output logic            flash,
	output logic            rel,
	output logic [1:0]      mode
);
	timeunit 1ns;
	timeprecision 100ps;
	int   cnt = 0, lo = 0, bc = 0, lc = 0;
	logic en_q = 1'b0, tx_q = 1'b0, sf = 1'b0, wake = 1'b0, loc = 1'b0;
	// power-up lands in stand-by with no wake flags
	initial begin
		mode = 2'h1;
		flash = 1'b0;
		rel = 1'b0;
	end
	always @(posedge clk) begin
		en_q <= en;
		tx_q <= txd;
		if (mode != 2'h2) begin
			cnt <= en ? cnt + 1 : 0;
			if (en && cnt >= MODE) begin
				mode <= 2'h2;
				{wake, loc, flash, rel, sf} <= 5'h00;
				cnt <= 0;
				lo <= 0;
			end
		end else if (en) begin
			lo <= 0;
			sf <= 1'b0;
			if (!en_q && sf && lo >= FL1) begin
				flash <= !flash;
				rel <= 1'b0;
				cnt <= 0;
			end else begin
				cnt <= txd ? cnt + 1 : 0;
				if (txd && cnt >= REL) rel <= 1'b1;
			end
		end else begin
			lo <= lo + 1;
			rel <= 1'b0;
			cnt <= 0;
			if (tx_q && !txd) sf <= 1'b1;
			// enable low with no transmit edge in time means sleep
			if (!sf && lo > 4 * FL1) mode <= 2'h0;
		end
		if (mode == 2'h0) begin
			bc <= bus_dom ? bc + 1 : 0;
			lc <= wk_n ? 0 : lc + 1;
			if (!bus_dom && bc > BW) begin
				mode <= 2'h1;
				wake <= 1'b1;
			end
			if (lc > LW) begin
				mode <= 2'h1;
				wake <= 1'b1;
				loc <= 1'b1;
			end
		end
	end
	// slope is not modelled, so flash only changes the flag
	wire logic bus = !bus_dom && !(mode == 2'h2 && rel && !txd);
	assign rxd = mode == 2'h0 ? 1'b1 : mode == 2'h1 ? !wake : bus;
	assign pd_strong = mode == 2'h1 && loc;
	assign pd_weak = mode == 2'h0 || (mode == 2'h1 && wake && !loc);
endmodule : lmc_xcvr_model

// >>> tb/tb.sv
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin bad_count++; \
	$display("BAD %0t got %h want %h", $time, a, b); end end
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk, rst, cyc, stb, we, ack, en, txd_o, txd_oe, rxd;
	logic        bus_dom, wk_n, pdw, pds, fl, rl;
	logic [1:0]  md;
	logic [3:0]  adr, sel;
	logic [31:0] dw, dr, s;
	int          bad_count, check_count;
	logic [3:0]  ta [5] = '{4'h8, 4'hC, 4'h4, 4'h0, 4'h2};
	logic [7:0]  te [5] = '{8'h10, 8'h00, 8'h01, 8'h00, 8'h00};
	// strong pull-down beats the host, weak one loses to it
	wire logic   txd_i = pds ? 1'b0 : txd_oe ? txd_o : !pdw;

	// probe and last flash phase keep their full defaults, so those counts get exercised
	lmc_ctrl #(.MODE_CYC(10), .RELEASE_CYC(10), .FL_ENLOW_CYC(10), .FL_TXA_CYC(10),
		.FL_TXB_CYC(10)) uut (
		.CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
		.WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dw), .WB_DAT_O(dr), .WB_ACK_O(ack),
		.EN(en), .TXD_O(txd_o), .TXD_OE(txd_oe), .TXD_I(txd_i), .RXD_I(rxd));

	lmc_xcvr_model dev (.clk(clk), .en(en), .txd(txd_i), .bus_dom(bus_dom), .wk_n(wk_n),
		.rxd(rxd), .pd_weak(pdw), .pd_strong(pds), .flash(fl), .rel(rl), .mode(md));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic stop_test;
		$display("checks %0d bad %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : stop_test

	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hF;
		dw <= d;
		// no cycle limit here: only the watchdog ends a hung request
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		s = dr;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk);
	endtask : wb

	task automatic wr(input logic [3:0] a, input logic [2:0] c);
		wb(1'b1, a, 32'(c));
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		wb(1'b0, a, 32'h0000_0000);
		`CHK(s, 32'(e))
	endtask : rd

	task automatic idle;
		int n;
		n = 0;
		do begin
			wb(1'b0, 4'h8, 32'h0000_0000);
			n++;
		end while (s[0] !== 1'b0 && n < 1000);
		`CHK(s[0], 1'b0)
	endtask : idle

	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		stop_test();
	end

	initial begin
		{rst, cyc, stb, we, adr, sel, dw} = {1'b1, 43'h000_0000_0000};
		{bus_dom, wk_n, bad_count, check_count} = {1'b0, 1'b1, 64'h0000_0000_0000_0000};
		repeat (16) @(posedge clk);
		`CHK({en, txd_oe, ack}, 3'h0)
		rst <= 1'b0;
		@(posedge clk);
		foreach (ta[i]) rd(ta[i], te[i]);
		wr(4'h0, 3'h4);
		idle();
		rd(4'hC, 8'h01);
		wr(4'h0, 3'h1);
		`CHK(en, 1'b1)
		idle();
		rd(4'h8, 8'h1A);
		`CHK({md, rl}, 3'h5)
		wr(4'h4, 3'h0);
		rd(4'h8, 8'h0A);
		wr(4'h4, 3'h1);
		wr(4'h0, 3'h3);
		idle();
		rd(4'h8, 8'h1E);
		`CHK(fl, 1'b1)
		wr(4'h0, 3'h3);
		idle();
		rd(4'h8, 8'h1A);
		`CHK({fl, rl}, 2'h1)
		wr(4'h0, 3'h3);
		idle();
		wr(4'h0, 3'h2);
		repeat (60) @(posedge clk);
		`CHK(md, 2'h0)
		rd(4'h8, 8'h10);
		wr(4'h0, 3'h3);
		rd(4'h8, 8'h30);
		bus_dom <= 1'b1;
		repeat (30) @(posedge clk);
		`CHK(md, 2'h0)
		bus_dom <= 1'b0;
		repeat (3) @(posedge clk);
		`CHK(md, 2'h1)
		wr(4'h0, 3'h4);
		idle();
		rd(4'hC, 8'h03);
		wr(4'h0, 3'h1);
		idle();
		rd(4'hC, 8'h00);
		`CHK(md, 2'h2)
		wr(4'h0, 3'h2);
		repeat (60) @(posedge clk);
		wk_n <= 1'b0;
		repeat (30) @(posedge clk);
		wk_n <= 1'b1;
		`CHK(md, 2'h1)
		wr(4'h0, 3'h4);
		idle();
		rd(4'hC, 8'h07);
		// reset in mid-run must drop the stored wake source and the pins
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		`CHK({en, txd_oe, ack}, 3'h0)
		rst <= 1'b0;
		@(posedge clk);
		rd(4'hC, 8'h00);
		// sleep while the mode change is still running
		wr(4'h0, 3'h1);
		wr(4'h0, 3'h2);
		rd(4'h8, 8'h00);
		rd(4'hC, 8'h00);
		stop_test();
	end
endmodule : tb
